// *** hdl/parallel_to_serial_shifter.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "shifter_defines.svh"

// What this block does
// R1: Eight stages load parallel inputs while low.
// R2: Parallel load overrides shifting, any clock state.
// R3: Held load keeps tracking parallel input changes.
// R4: Shift only on combined clock rising edge.
// R5: Serial input enters first; stages move right.
// R6: Shift clock is OR of both inputs.
// R7: A high clock input inhibits the other.
// R8: Rising inhibit with other low clocks once.
// R9: Last stage drives true and complement outputs.
// R10: Host keeps load high while shifting.
// R11: Sample pins; detect OR rising edge synchronously.
module parallel_to_serial_shifter (
    // System clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Host pins, asynchronous to mclk.
    input wire logic parallel_load_n,
    input wire logic serial_in,
    input wire logic clock_in_a,
    input wire logic clock_in_b,
    input wire shifter_pkg::stage_vec_t parallel_in,
    // Serial outputs.
    output logic last_stage_out,
    output logic last_stage_out_n
);
    import shifter_pkg::*;

    // Each control pin passes three flops; a change counts once stages two and three agree.
    pin_ctl_t sync1_r;
    pin_ctl_t sync2_r;
    pin_ctl_t sync3_r;
    pin_ctl_t ctl_r;
    stage_vec_t par1_r;
    stage_vec_t par2_r;
    stage_vec_t par3_r;
    stage_vec_t par_r;
    stage_vec_t stages_r;
    stage_vec_t stages_nxt;
    logic or_clk_prev_r;
    pin_ctl_t pin_now;
    pin_ctl_t ctl_nxt;
    stage_vec_t par_nxt;
    logic or_clk;
    logic shift_edge;
    logic last_n_r;
    // Reset image of the stages, kept as a constant so single bits can be picked from it.
    localparam stage_vec_t stage_init = `STAGE_RESET;

    assign pin_now = '{load_n: parallel_load_n, clk_a: clock_in_a, clk_b: clock_in_b,
                       serial: serial_in};
    // Hold the last agreed value while stages two and three disagree.
    assign ctl_nxt = (sync2_r ^ sync3_r) & ctl_r | ~(sync2_r ^ sync3_r) & sync3_r;
    assign par_nxt = (par2_r ^ par3_r) & par_r | ~(par2_r ^ par3_r) & par3_r;

    assign or_clk = ctl_r.clk_a | ctl_r.clk_b; // R6 R7
    // A rising inhibit with the other input low is an edge too, as on the real part.
    assign shift_edge = or_clk & ~or_clk_prev_r; // R4 R8 R11

    // Load is a level and wins every cycle it is seen; an edge arriving under load is
    // dropped, not held over until load is released.
    assign stages_nxt = !ctl_r.load_n ? par_r :                                   // R1 R2 R3
                        shift_edge ? {stages_r[`LAST_STAGE-1:0], ctl_r.serial} :   // R5
                        stages_r;                                                  // R4

    // The filters come up at the idle pin levels, so the release of reset
    // never looks like a clock edge or a load.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sync1_r <= `CTL_IDLE;
            sync2_r <= `CTL_IDLE;
            sync3_r <= `CTL_IDLE;
            ctl_r <= `CTL_IDLE;
            last_n_r <= ~stage_init[`LAST_STAGE];
            par1_r <= `STAGE_RESET;
            par2_r <= `STAGE_RESET;
            par3_r <= `STAGE_RESET;
            par_r <= `STAGE_RESET;
            stages_r <= `STAGE_RESET;
            or_clk_prev_r <= 1'b0;
        end else begin
            sync1_r <= pin_now;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            ctl_r <= ctl_nxt;
            par1_r <= parallel_in;
            par2_r <= par1_r;
            par3_r <= par2_r;
            par_r <= par_nxt;
            stages_r <= stages_nxt;
            or_clk_prev_r <= or_clk;
            last_n_r <= ~stages_nxt[`LAST_STAGE];
        end
    end

    // Only the last stage is visible. The complement has a flop of its own, so both
    // outputs come straight from registers and switch on the same edge.
    assign last_stage_out = stages_r[`LAST_STAGE]; // R9
    assign last_stage_out_n = last_n_r; // R9

    property p_load_follows;
        @(posedge mclk) disable iff (!rst_n) !ctl_r.load_n |=> stages_r == $past(par_r);
    endproperty
    a_load_follows: assert property (p_load_follows) else $error("load did not copy inputs"); // R1

    property p_load_overrides;
        @(posedge mclk) disable iff (!rst_n)
            (!ctl_r.load_n && shift_edge) |=> stages_r == $past(par_r);
    endproperty
    a_load_overrides: assert property (p_load_overrides) else $error("shift beat load"); // R2

    property p_track;
        @(posedge mclk) disable iff (!rst_n)
            (!ctl_r.load_n && $changed(par_r)) |=> stages_r == $past(par_r);
    endproperty
    a_track: assert property (p_track) else $error("load did not track inputs"); // R3

    property p_hold;
        @(posedge mclk) disable iff (!rst_n)
            (ctl_r.load_n && !shift_edge) |=> $stable(stages_r);
    endproperty
    a_hold: assert property (p_hold) else $error("stages changed without edge"); // R4

    property p_shift;
        @(posedge mclk) disable iff (!rst_n)
            (ctl_r.load_n && shift_edge) |=>
                stages_r == {$past(stages_r[`LAST_STAGE-1:0]), $past(ctl_r.serial)};
    endproperty
    a_shift: assert property (p_shift) else $error("wrong right shift"); // R5

    property p_either_clock;
        @(posedge mclk) disable iff (!rst_n)
            (ctl_r.load_n && !or_clk_prev_r && (ctl_r.clk_a || ctl_r.clk_b)) |=>
                stages_r[0] == $past(ctl_r.serial);
    endproperty
    a_either_clock: assert property (p_either_clock) else $error("clock input ignored"); // R6

    property p_inhibit;
        @(posedge mclk) disable iff (!rst_n)
            (ctl_r.load_n && or_clk_prev_r && (ctl_r.clk_a || ctl_r.clk_b)) |=> $stable(stages_r);
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("inhibit did not hold"); // R7

    property p_outputs;
        @(posedge mclk) disable iff (!rst_n)
            last_stage_out == stages_r[`LAST_STAGE] &&
                last_stage_out_n == ~stages_r[`LAST_STAGE];
    endproperty
    a_outputs: assert property (p_outputs) else $error("outputs not complementary"); // R9

    // Both outputs must leave reset at the reset image of the last stage.
    property p_reset_state;
        @(posedge mclk) !rst_n |=> last_stage_out == stage_init[`LAST_STAGE] &&
            last_stage_out_n == ~stage_init[`LAST_STAGE];
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("outputs wrong after reset"); // R9

    // The complement flop is fed from the next-state path; it must move with the true output.
    property p_shift_out;
        @(posedge mclk) disable iff (!rst_n)
            (ctl_r.load_n && shift_edge) |=>
                last_stage_out == $past(stages_r[`LAST_STAGE-1]) &&
                last_stage_out_n == ~$past(stages_r[`LAST_STAGE-1]);
    endproperty
    a_shift_out: assert property (p_shift_out) else $error("output missed the shift"); // R9

    property p_load_clocked;
        @(posedge mclk) disable iff (!rst_n)
            (!ctl_r.load_n && (ctl_r.clk_a || ctl_r.clk_b)) |=> stages_r == $past(par_r);
    endproperty
    a_load_clocked: assert property (p_load_clocked) else $error("clock broke load"); // R2

    // Either input alone, with the other low throughout, must give one full right shift.
    property p_clock_a_alone;
        @(posedge mclk) disable iff (!rst_n)
            (ctl_r.load_n && $rose(ctl_r.clk_a) && !ctl_r.clk_b && !$past(ctl_r.clk_b)) |=>
                stages_r == {$past(stages_r[`LAST_STAGE-1:0]), $past(ctl_r.serial)};
    endproperty
    a_clock_a_alone: assert property (p_clock_a_alone) else $error("clock a ignored"); // R6 R8

    property p_clock_b_alone;
        @(posedge mclk) disable iff (!rst_n)
            (ctl_r.load_n && $rose(ctl_r.clk_b) && !ctl_r.clk_a && !$past(ctl_r.clk_a)) |=>
                stages_r == {$past(stages_r[`LAST_STAGE-1:0]), $past(ctl_r.serial)};
    endproperty
    a_clock_b_alone: assert property (p_clock_b_alone) else $error("clock b ignored"); // R6 R8

    // Raising one input while the other is already high is the clean inhibit: no shift.
    property p_inhibit_rise;
        @(posedge mclk) disable iff (!rst_n)
            (ctl_r.load_n && (($rose(ctl_r.clk_a) && ctl_r.clk_b && $past(ctl_r.clk_b)) ||
                ($rose(ctl_r.clk_b) && ctl_r.clk_a && $past(ctl_r.clk_a)))) |=>
                $stable(stages_r);
    endproperty
    a_inhibit_rise: assert property (p_inhibit_rise) else $error("inhibit rise shifted"); // R8

    // A filtered pin may only move to a value that stages two and three agreed on.
    property p_settle_ctl;
        @(posedge mclk) disable iff (!rst_n)
            ((ctl_r ^ $past(ctl_r)) & ($past(sync2_r) ^ $past(sync3_r))) == 4'h0 &&
            (($past(sync2_r) ~^ $past(sync3_r)) & (ctl_r ^ $past(sync3_r))) == 4'h0;
    endproperty
    a_settle_ctl: assert property (p_settle_ctl) else $error("control filter slipped"); // R11

    property p_settle_par;
        @(posedge mclk) disable iff (!rst_n)
            ((par_r ^ $past(par_r)) & ($past(par2_r) ^ $past(par3_r))) == 8'h00 &&
            (($past(par2_r) ~^ $past(par3_r)) & (par_r ^ $past(par3_r))) == 8'h00;
    endproperty
    a_settle_par: assert property (p_settle_par) else $error("data filter slipped"); // R11

    // Every stage past the first takes its neighbour's old content on a shift.
    for (genvar k = 1; k < `STAGE_COUNT; k++) begin : g_move
        property p_move;
            @(posedge mclk) disable iff (!rst_n)
                (ctl_r.load_n && shift_edge) |=> stages_r[k] == $past(stages_r[k-1]);
        endproperty
        a_move: assert property (p_move) else $error("stage did not move right"); // R5
    end
endmodule : parallel_to_serial_shifter

`default_nettype wire

// *** include/shifter_defines.svh ***
`ifndef SHIFTER_DEFINES_SVH
`define SHIFTER_DEFINES_SVH

`define STAGE_COUNT 8
`define STAGE_RESET 8'h00
`define LAST_STAGE 7
`define SYNC_DEPTH 3
// Idle pin image for the filters: load inactive high, clocks and serial low.
`define CTL_IDLE 4'h8

`endif

// *** include/shifter_pkg.sv ***
`default_nettype none
`include "shifter_defines.svh"

package shifter_pkg;
    typedef logic [`STAGE_COUNT-1:0] stage_vec_t;
    typedef struct packed {
        logic load_n;
        logic clk_a;
        logic clk_b;
        logic serial;
    } pin_ctl_t;
    typedef struct packed {
        logic q_true;
        logic q_comp;
    } serial_out_t;
endpackage : shifter_pkg

`default_nettype wire

// *** tb/host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module host_model (
    // Bench clock in, shifter pins out.
    input wire logic mclk,
    output var shifter_pkg::pin_ctl_t pins,
    output var shifter_pkg::stage_vec_t par
);
    initial {pins, par} = {4'h8, 8'h00};
    // Each level stands four cycles, longer than the pin filter needs.
    task automatic step(input logic a, input logic b, input logic d);
        pins[2:0] <= {a, b, d};
        repeat (4) @(negedge mclk);
    endtask : step
    task automatic load(input logic low, input shifter_pkg::stage_vec_t v);
        par <= v;
        pins.load_n <= ~low;
        repeat (8) @(negedge mclk);
    endtask : load
endmodule : host_model
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHECK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD %0t mismatch", $time); end end
module tb;
    import shifter_pkg::*;
    logic mclk = 1'b0, rst_n = 1'b0, q, q_n;
    pin_ctl_t pins;
    stage_vec_t par;
    int miscompares, check_count, cycles;
    host_model i_host_model (.mclk(mclk), .pins(pins), .par(par));
    parallel_to_serial_shifter i_parallel_to_serial_shifter (.mclk(mclk), .rst_n(rst_n),
        .parallel_load_n(pins.load_n), .serial_in(pins.serial), .clock_in_a(pins.clk_a),
        .clock_in_b(pins.clk_b), .parallel_in(par), .last_stage_out(q), .last_stage_out_n(q_n));
    task automatic look(input logic b);
        `CHECK({q, q_n}, {b, ~b})
    endtask : look
    task automatic load_test();
        i_host_model.load(1'b1, 8'h00);
        i_host_model.load(1'b1, 8'hA0);
        look(1'b1);
        i_host_model.step(1'b1, 1'b0, 1'b0);
        i_host_model.step(1'b0, 1'b0, 1'b0);
        look(1'b1);
        i_host_model.load(1'b0, 8'hA0);
        $display("load test done");
    endtask : load_test
    task automatic inhibit_test();
        logic [11:0] s = 12'h1DE;
        for (int i = 0; i < 6; i++) i_host_model.step(s[2*i+1], s[2*i], 1'b0);
        look(1'b0);
        $display("inhibit test done");
    endtask : inhibit_test
    task automatic shift_test();
        stage_vec_t v = 8'h50;
        i_host_model.load(1'b1, v);
        i_host_model.load(1'b0, v);
        look(v[7]);
        for (int k = 0; k < 14; k++) begin
            i_host_model.step(1'b0, 1'b0, v[k%8]);
            i_host_model.step(k < 7, k > 6, v[k%8]);
            i_host_model.step(1'b0, 1'b0, v[k%8]);
            look(k < 7 ? v[6-k] : v[k-7]);
        end
        $display("shift test done");
    endtask : shift_test
    task automatic complete_run();
        miscompares += (cycles >= 3000);
        $display("checks %0d bad %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run
    initial forever #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) complete_run();
    end
    initial begin
        repeat (12) @(negedge mclk);
        look(1'b0);
        rst_n <= 1'b1;
        @(negedge mclk);
        load_test();
        inhibit_test();
        shift_test();
        complete_run();
    end
endmodule : tb
`default_nettype wire
